/* File: design/xtm_pkg.sv */
// Package for the XOR and timer-mode move datapath.
// Assumes a single-clock core with an internal instruction decoder.
`default_nettype none

package xtm_pkg;
  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int XTM_DATA_W = 8;
  localparam int XTM_ADDR_W = 6;
  localparam int XTM_OP_W = 3;
  localparam logic [7:0] XTM_ACCUM_RST = 8'h00;
  localparam logic [7:0] XTM_T0_MODE_RST = 8'h00;

  // ---------------------------------------------------------------
  // Operation codes from the decoder
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    XTM_OP_NOP = 3'h0,
    XTM_OP_LOAD_T0 = 3'h1,
    XTM_OP_READ_T0 = 3'h2,
    XTM_OP_XOR_REG = 3'h3,
    XTM_OP_XOR_IMM = 3'h4
  } xtm_op_e;
endpackage

`default_nettype wire

/* File: design/xtm_datapath.sv */
// Execution datapath for four accumulator instructions.
// Assumes the decoder issues one operation per instruction-cycle enable
// and supplies the addressed register's value on the same cycle.
`timescale 1ns/1ns
`default_nettype none

module xtm_datapath
  import xtm_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Decoder issue
  input wire logic i_inst_en,
  input wire logic [2:0] i_op,
  input wire logic [XTM_ADDR_W-1:0] i_reg_addr,
  input wire logic i_dest_sel,
  input wire logic [XTM_DATA_W-1:0] i_imm,
  input wire logic [XTM_DATA_W-1:0] i_reg_rdata,
  // Flags in from status register
  input wire logic i_carry,
  input wire logic i_dcarry,
  // Results
  output logic [XTM_DATA_W-1:0] o_accumulator,
  output logic [XTM_DATA_W-1:0] o_timer0_mode_register,
  output logic o_reg_we,
  output logic [XTM_ADDR_W-1:0] o_reg_waddr,
  output logic [XTM_DATA_W-1:0] o_reg_wdata,
  output logic o_zero,
  output logic o_zero_we,
  output logic o_carry,
  output logic o_dcarry
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic load_timer0_mode_instr;
  logic read_timer0_mode_instr;
  logic xor_acc_with_reg_instr;
  logic xor_imm_with_acc_instr;
  logic [XTM_DATA_W-1:0] xor_res;

  // Codes 5 to 7 decode to nothing and act as a no-operation
  assign load_timer0_mode_instr = i_inst_en && (i_op == XTM_OP_LOAD_T0);
  assign read_timer0_mode_instr = i_inst_en && (i_op == XTM_OP_READ_T0);
  assign xor_acc_with_reg_instr = i_inst_en && (i_op == XTM_OP_XOR_REG);
  assign xor_imm_with_acc_instr = i_inst_en && (i_op == XTM_OP_XOR_IMM);

  // One shared XOR; operand picked by the instruction
  assign xor_res = o_accumulator ^
    (xor_imm_with_acc_instr ? i_imm : i_reg_rdata);

  // ---------------------------------------------------------------
  // Accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_accumulator <= XTM_ACCUM_RST;
    // One op per cycle, so this priority order never has to decide
    end else if (read_timer0_mode_instr) begin
      o_accumulator <= o_timer0_mode_register;
    end else if (xor_acc_with_reg_instr && !i_dest_sel) begin
      o_accumulator <= xor_res;
    end else if (xor_imm_with_acc_instr) begin
      o_accumulator <= xor_res;
    end
  end

  // ---------------------------------------------------------------
  // Timer-0 mode register
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer0_mode_register <= XTM_T0_MODE_RST;
    end else if (load_timer0_mode_instr) begin
      o_timer0_mode_register <= o_accumulator;
    end
  end

  // ---------------------------------------------------------------
  // Register write-back
  // ---------------------------------------------------------------
  // Address and data follow every cycle; only o_reg_we qualifies them.
  // The register file commits one cycle late: a reader of the same
  // register on the next instruction must be forwarded outside.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_we <= 1'b0;
      o_reg_waddr <= '0;
      o_reg_wdata <= '0;
    end else begin
      o_reg_we <= xor_acc_with_reg_instr && i_dest_sel;
      o_reg_waddr <= i_reg_addr;
      o_reg_wdata <= xor_res;
    end
  end

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  // Only the XORs touch Z; moves leave every flag alone
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_zero <= 1'b0;
      o_zero_we <= 1'b0;
    end else begin
      o_zero_we <= xor_acc_with_reg_instr || xor_imm_with_acc_instr;
      if (xor_acc_with_reg_instr || xor_imm_with_acc_instr) begin
        o_zero <= (xor_res == '0);
      end
    end
  end

  // Carry flags pass through untouched
  // The status register owns C and DC; this is only a registered echo
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_carry <= 1'b0;
      o_dcarry <= 1'b0;
    end else begin
      o_carry <= i_carry;
      o_dcarry <= i_dcarry;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Attempts that overlap reset are dropped rather than judged
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // ---------------------------------------------------------------
  // Moves
  // ---------------------------------------------------------------
  a_load_t0_copy: assert property (
    load_timer0_mode_instr |=> o_timer0_mode_register == $past(o_accumulator))
    else $error("timer mode load wrong");

  a_t0_hold: assert property (
    !load_timer0_mode_instr |=> $stable(o_timer0_mode_register))
    else $error("timer mode changed without load");

  a_read_t0_copy: assert property (
    read_timer0_mode_instr |=> o_accumulator == $past(o_timer0_mode_register))
    else $error("timer mode read wrong");

  a_move_no_zero: assert property (
    (load_timer0_mode_instr || read_timer0_mode_instr) |=> !o_zero_we)
    else $error("move touched zero flag");

  a_acc_hold: assert property (
    !(read_timer0_mode_instr || xor_imm_with_acc_instr ||
      (xor_acc_with_reg_instr && !i_dest_sel)) |=> $stable(o_accumulator))
    else $error("accumulator changed without a writer");

  // ---------------------------------------------------------------
  // Exclusive-OR and flags
  // ---------------------------------------------------------------
  a_xor_reg_acc: assert property (
    (xor_acc_with_reg_instr && !i_dest_sel)
      |=> o_accumulator == ($past(o_accumulator) ^ $past(i_reg_rdata)))
    else $error("register xor to accumulator wrong");

  a_xor_reg_wb: assert property (
    (xor_acc_with_reg_instr && i_dest_sel) |=> o_reg_we &&
      o_reg_waddr == $past(i_reg_addr) && $stable(o_accumulator) &&
      o_reg_wdata == ($past(o_accumulator) ^ $past(i_reg_rdata)))
    else $error("register xor write-back wrong");

  a_reg_we_only: assert property (
    !(xor_acc_with_reg_instr && i_dest_sel) |=> !o_reg_we)
    else $error("register write without register xor");

  a_xor_imm_acc: assert property (
    xor_imm_with_acc_instr
      |=> o_accumulator == ($past(o_accumulator) ^ $past(i_imm)))
    else $error("immediate xor wrong");

  a_zero_flag: assert property (
    xor_imm_with_acc_instr |=> o_zero_we &&
      o_zero == (($past(o_accumulator) ^ $past(i_imm)) == 8'h00))
    else $error("zero flag after immediate xor wrong");

  a_zero_reg: assert property (
    xor_acc_with_reg_instr |=> o_zero_we &&
      o_zero == (($past(o_accumulator) ^ $past(i_reg_rdata)) == 8'h00))
    else $error("zero flag after register xor wrong");

  a_zero_hold: assert property (
    !(xor_acc_with_reg_instr || xor_imm_with_acc_instr)
      |=> !o_zero_we && $stable(o_zero))
    else $error("zero flag changed without xor");

  a_refused_quiet: assert property (
    (i_inst_en && (i_op > XTM_OP_XOR_IMM)) |=> !o_reg_we && !o_zero_we &&
      $stable(o_accumulator) && $stable(o_timer0_mode_register))
    else $error("unknown operation changed state");

  a_carry_kept: assert property (
    1'b1 |=> o_carry == $past(i_carry) && o_dcarry == $past(i_dcarry))
    else $error("carry flags altered");

  // ---------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------
  // Main scenarios: each move, each destination, a zero result
  c_load_t0: cover property (load_timer0_mode_instr);
  c_read_t0: cover property (read_timer0_mode_instr);
  c_xor_reg_wb: cover property (xor_acc_with_reg_instr && i_dest_sel);
  c_xor_reg_acc: cover property (xor_acc_with_reg_instr && !i_dest_sel);
  c_xor_zero: cover property (xor_imm_with_acc_instr ##1 o_zero);

endmodule // xtm_datapath

`default_nettype wire

/* File: verif/test_xor_and_timer_mode_moves.sv */
// Testbench for the XOR and timer-mode move datapath.
// Drives the decoder side itself; no partner model.
`timescale 1ns/1ns
`default_nettype none
module test_xor_and_timer_mode_moves;
  import xtm_pkg::*;
  logic clk, rst_n, en, dsel, cy, dc, we, zero, zwe, ocy, odc;
  logic [2:0] op;
  logic [5:0] addr, wa;
  logic [7:0] imm, rd, accum, t0, wd;
  int errors, checks_done;

  // ---------------------------------------------------------------
  // Device and clock
  // ---------------------------------------------------------------
  xtm_datapath u_dut (.i_mclk(clk), .i_rst_n(rst_n), .i_inst_en(en),
    .i_op(op), .i_reg_addr(addr), .i_dest_sel(dsel), .i_imm(imm),
    .i_reg_rdata(rd), .i_carry(cy), .i_dcarry(dc), .o_accumulator(accum),
    .o_timer0_mode_register(t0), .o_reg_we(we), .o_reg_waddr(wa),
    .o_reg_wdata(wd), .o_zero(zero), .o_zero_we(zwe), .o_carry(ocy),
    .o_dcarry(odc));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Compare and drive
  // ---------------------------------------------------------------
  // Narrow outputs are zero-extended; !== lets no unknown slip through
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks_done++;
    if (e !== g) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One instruction, taken at the next edge; the enable stays high so
  // calls run back to back, and outputs are settled 1 ns after the edge
  task automatic issue(input logic [2:0] o, input logic [5:0] a,
      input logic d, input logic [7:0] i, r);
    en = 1'b1;
    op = o;
    addr = a;
    dsel = d;
    imm = i;
    rd = r;
    @(posedge clk);
    #1;
  endtask

  // Enable low for one cycle; the operands left behind must do nothing
  task automatic pause;
    en = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_xor_imm;
    issue(XTM_OP_XOR_IMM, 6'h00, 1'b0, 8'hF0, 8'h00);
    chk("accum", 8'hF0, accum);
    issue(XTM_OP_XOR_IMM, 6'h00, 1'b0, 8'hA5, 8'h00);
    chk("accum", 8'h55, accum);
    chk("zero", 8'h00, zero);
    chk("carry", 8'h00, ocy);
    chk("dcarry", 8'h01, odc);
    issue(XTM_OP_XOR_IMM, 6'h00, 1'b0, 8'h55, 8'h00);
    chk("accum", 8'h00, accum);
    chk("zero", 8'h01, zero);
    chk("zero_we", 8'h01, zwe);
  endtask

  task automatic t_xor_reg;
    issue(XTM_OP_XOR_IMM, 6'h00, 1'b0, 8'hF0, 8'h00);
    issue(XTM_OP_XOR_REG, 6'h05, 1'b1, 8'h00, 8'hA5);
    chk("reg_we", 8'h01, we);
    chk("waddr", 8'h05, wa);
    chk("wdata", 8'h55, wd);
    chk("accum", 8'hF0, accum);
    chk("zero", 8'h00, zero);
    chk("zero_we", 8'h01, zwe);
    issue(XTM_OP_XOR_REG, 6'h3F, 1'b0, 8'h00, 8'hF0);
    chk("reg_we", 8'h00, we);
    chk("accum", 8'h00, accum);
    chk("zero", 8'h01, zero);
  endtask

  task automatic t_timer;
    issue(XTM_OP_XOR_IMM, 6'h00, 1'b0, 8'h3C, 8'h00);
    issue(XTM_OP_LOAD_T0, 6'h00, 1'b0, 8'h00, 8'h00);
    chk("t0", 8'h3C, t0);
    chk("accum", 8'h3C, accum);
    chk("zero", 8'h00, zero);
    chk("zero_we", 8'h00, zwe);
    issue(XTM_OP_XOR_IMM, 6'h00, 1'b0, 8'h3C, 8'h00);
    issue(XTM_OP_READ_T0, 6'h00, 1'b0, 8'h00, 8'h00);
    chk("accum", 8'h3C, accum);
    chk("t0", 8'h3C, t0);
    chk("zero", 8'h01, zero);
    chk("zero_we", 8'h00, zwe);
  endtask

  // Refused cycles: enable low, then an unknown code and a no-op code
  task automatic t_idle;
    cy = 1'b1;
    dc = 1'b0;
    op = XTM_OP_XOR_IMM;
    imm = 8'hFF;
    pause();
    chk("accum", 8'h3C, accum);
    chk("carry", 8'h01, ocy);
    chk("dcarry", 8'h00, odc);
    chk("zero_we", 8'h00, zwe);
    issue(3'h7, 6'h01, 1'b1, 8'hFF, 8'hFF);
    chk("reg_we", 8'h00, we);
    chk("accum", 8'h3C, accum);
    chk("t0", 8'h3C, t0);
    issue(XTM_OP_NOP, 6'h01, 1'b0, 8'hFF, 8'hFF);
    chk("accum", 8'h3C, accum);
    chk("zero", 8'h01, zero);
    pause();
  endtask

  // Reset in mid-run clears state at once; the first instruction may
  // follow on the first edge after release
  task automatic t_reset;
    rst_n = 1'b0;
    #1;
    chk("accum", XTM_ACCUM_RST, accum);
    chk("t0", XTM_T0_MODE_RST, t0);
    chk("zero", 8'h00, zero);
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    issue(XTM_OP_XOR_IMM, 6'h00, 1'b0, 8'h0F, 8'h00);
    chk("accum", 8'h0F, accum);
    chk("zero", 8'h00, zero);
    pause();
  endtask

  // ---------------------------------------------------------------
  // Verdict and run
  // ---------------------------------------------------------------
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang uses up this bound and counts as a mismatch
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    en = 1'b0;
    op = 3'h0;
    addr = 6'h00;
    dsel = 1'b0;
    imm = 8'h00;
    rd = 8'h00;
    cy = 1'b0;
    dc = 1'b1;
    errors = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("accum", XTM_ACCUM_RST, accum);
    chk("t0", XTM_T0_MODE_RST, t0);
    t_xor_imm();
    t_xor_reg();
    t_timer();
    t_idle();
    t_reset();
    print_verdict();
  end
endmodule // test_xor_and_timer_mode_moves
`default_nettype wire
